/* File: frame_map_pkg.sv */
// Frame layout constants and position helpers shared by both ends of the line.
package frame_map_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned LINE_BIT_HZ = 784_000;
  localparam int unsigned BIT_DIV = CLK_HZ / LINE_BIT_HZ;
  localparam logic [13:0] SYNC_PATTERN = 14'h3ca5;
  localparam logic [12:0] SYNC_LAST = 13'h000e;
  localparam logic [12:0] FAR_LOSS_POS = 13'h000f;
  localparam logic [12:0] FAR_ERR_POS = 13'h0010;
  localparam logic [12:0] GRP1_PAY_FIRST = 13'h0011;
  localparam logic [12:0] GRP1_PAY_LAST = 13'h049c;
  localparam logic [12:0] GRP1_OH_LAST = 13'h04a6;
  localparam logic [12:0] GRP2_PAY_LAST = 13'h0932;
  localparam logic [12:0] GRP2_OH_LAST = 13'h093c;
  localparam logic [12:0] GRP3_PAY_LAST = 13'h0dc8;
  localparam logic [12:0] GRP3_OH_LAST = 13'h0dd2;
  localparam logic [12:0] GRP4_PAY_LAST = 13'h125e;
  localparam logic [12:0] STUFFED_LAST = 13'h1262;
  localparam logic [12:0] OH_OFS1 = 13'h048c;
  localparam logic [12:0] OH_OFS2 = 13'h0918;
  localparam logic [12:0] OH_OFS3 = 13'h0da4;
  localparam logic [12:0] OH_OFS4 = 13'h1230;
  localparam int unsigned OH_COUNT = 50;
  localparam logic [5:0] OH_PWR1 = 6'h17;
  localparam logic [5:0] OH_PWR2 = 6'h18;
  localparam logic [5:0] OH_PAD_SYMBOL1_SIGN = 6'h2f;
  localparam logic [5:0] OH_PAD_SYMBOL2_MAGNITUDE = 6'h32;
  localparam logic SPARE_FILL = 1'b0;
  localparam int unsigned FIFO_WIDTH = 8;
  localparam int unsigned FIFO_DEPTH = 8;

  // Position helpers; payload ranges and the overhead slots never overlap.
  function automatic logic is_payload(input logic [12:0] pos);
    is_payload = (pos >= GRP1_PAY_FIRST && pos <= GRP1_PAY_LAST) ||
                 (pos > GRP1_OH_LAST && pos <= GRP2_PAY_LAST) ||
                 (pos > GRP2_OH_LAST && pos <= GRP3_PAY_LAST) ||
                 (pos > GRP3_OH_LAST && pos <= GRP4_PAY_LAST);
  endfunction

  function automatic logic [5:0] oh_index(input logic [12:0] pos);
    logic [12:0] idx;
    idx = 13'h0000;
    if (pos == FAR_LOSS_POS || pos == FAR_ERR_POS) begin
      idx = pos;
    end else if (pos > GRP1_PAY_LAST && pos <= GRP1_OH_LAST) begin
      idx = pos - OH_OFS1;
    end else if (pos > GRP2_PAY_LAST && pos <= GRP2_OH_LAST) begin
      idx = pos - OH_OFS2;
    end else if (pos > GRP3_PAY_LAST && pos <= GRP3_OH_LAST) begin
      idx = pos - OH_OFS3;
    end else if (pos > GRP4_PAY_LAST && pos <= STUFFED_LAST) begin
      idx = pos - OH_OFS4;
    end
    oh_index = idx[5:0];
  endfunction
endpackage

/* File: frame_link_if.sv */
// Serial line between the framer and the deframer.
`timescale 1ns/1ps
interface frame_link_if;
  logic line_bit;
  logic line_en;
  modport tx (output line_bit, output line_en);
  modport rx (input line_bit, input line_en);
endinterface

/* File: sync_fifo.sv */
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module sync_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // sync_fifo

/* File: line_framer.sv */
// Transmit end: builds each line frame from payload bytes and overhead inputs.
// Summary of operation
// - Frame opens with fourteen-bit doubled sync pattern.
// - Bits 15 and 16 carry loss, block error.
// - Blocks 1-12, then overhead 17-26 in order.
// - Power status bits meaningful only customer-to-line.
// - Blocks 13-24, then message 1-4, checks, regenerator.
// - Blocks 25-36, then message 5-8, checks, ready bit.
// - Blocks 37-48 end at 4702 when unstuffed.
// - Stuffing adds sign, magnitude of two pad symbols.
// - Stuffed frame extends through bit 4706.
// - Overhead numbered 1 to 50 by fixed position.
// - Pad symbols inserted together; receiver infers length.
`timescale 1ns/1ps
module line_framer
  import frame_map_pkg::*;
#(
  parameter logic CUSTOMER_SIDE = 1'b1,
  // Cycles per line bit; only a testbench should shorten it, as the line rate depends on it.
  parameter int unsigned TICK_DIV = BIT_DIV
) (
  input wire logic clk,
  input wire logic arst_n,
  frame_link_if.tx link,
  input wire logic [7:0] pay_data,
  input wire logic pay_valid,
  output logic pay_ready,
  input wire logic far_loss,
  input wire logic far_block_err,
  input wire logic ops_channel_addr_bit_a,
  input wire logic ops_channel_addr_bit_b,
  input wire logic ops_channel_opcode_bit,
  input wire logic ops_channel_parity_byte_bit,
  input wire logic [7:0] ops_message,
  input wire logic [5:0] check_bits,
  input wire logic power_state_bit_1,
  input wire logic power_state_bit_2,
  input wire logic violation,
  input wire logic regen_present,
  input wire logic ready_to_receive,
  input wire logic stuff_req,
  input wire logic pad_symbol1_sign,
  input wire logic pad_symbol1_magnitude,
  input wire logic pad_symbol2_sign,
  input wire logic pad_symbol2_magnitude,
  output logic frame_start,
  output logic underrun
);
  logic [6:0] div_q;
  logic bit_tick;
  logic [12:0] pos_q;
  logic [12:0] last_pos_q;
  logic [OH_COUNT:1] oh_q;
  logic [OH_COUNT:1] oh_d;
  logic [7:0] shift_q;
  logic [3:0] shift_cnt_q;
  logic [7:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic line_bit_q;
  logic line_en_q;
  logic frame_start_q;
  logic underrun_q;
  logic [5:0] idx;
  logic pay_slot;
  logic at_end;

  sync_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_data(pay_data),
    .in_valid(pay_valid),
    .in_ready(pay_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  // Line bit rate is a one-cycle enable from the system clock.
  // The seven-bit divider limits the bit period to 128 cycles.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 7'h00;
    end else if (div_q == 7'(TICK_DIV - 1)) begin
      div_q <= 7'h00;
    end else begin
      div_q <= div_q + 7'h01;
    end
  end
  assign bit_tick = (div_q == 7'(TICK_DIV - 1));

  assign idx = oh_index(pos_q);
  assign pay_slot = is_payload(pos_q);
  assign at_end = (pos_q == last_pos_q);
  // A byte is taken only once the previous one has been fully sent.
  assign fifo_pop = bit_tick && pay_slot && (shift_cnt_q == 4'h0) && fifo_valid;

  // Overhead snapshot, numbered 1 to 50; sync occupies 1 to 14.
  always_comb begin
    oh_d = '0;
    oh_d[14:1] = SYNC_PATTERN;
    oh_d[15] = far_loss;
    oh_d[16] = far_block_err;
    oh_d[17] = ops_channel_addr_bit_a;
    oh_d[18] = ops_channel_addr_bit_b;
    oh_d[19] = ops_channel_opcode_bit;
    oh_d[20] = ops_channel_parity_byte_bit;
    oh_d[22:21] = check_bits[1:0];
    // The line-side end has no power status to report, so it sends the fill value.
    oh_d[OH_PWR1] = CUSTOMER_SIDE ? power_state_bit_1 : SPARE_FILL;
    oh_d[OH_PWR2] = CUSTOMER_SIDE ? power_state_bit_2 : SPARE_FILL;
    oh_d[25] = violation;
    oh_d[26] = SPARE_FILL;
    oh_d[30:27] = ops_message[3:0];
    oh_d[32:31] = check_bits[3:2];
    oh_d[33] = regen_present;
    oh_d[36:34] = {3{SPARE_FILL}};
    oh_d[40:37] = ops_message[7:4];
    oh_d[42:41] = check_bits[5:4];
    oh_d[43] = SPARE_FILL;
    oh_d[44] = ready_to_receive;
    oh_d[46:45] = {2{SPARE_FILL}};
    oh_d[47] = pad_symbol1_sign;
    oh_d[48] = pad_symbol1_magnitude;
    oh_d[49] = pad_symbol2_sign;
    oh_d[50] = pad_symbol2_magnitude;
  end

  // Position counter; frame length is fixed at the first bit of each frame.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_q <= 13'h0001;
      last_pos_q <= GRP4_PAY_LAST;
    end else if (bit_tick) begin
      if (at_end) begin
        pos_q <= 13'h0001;
      end else begin
        pos_q <= pos_q + 13'h0001;
      end
      if (pos_q == 13'h0001) begin
        // A stuff request that arrives mid-frame waits for the next frame's first bit.
        // Both pad symbols go in or neither does.
        last_pos_q <= stuff_req ? STUFFED_LAST : GRP4_PAY_LAST;
      end
    end
  end

  // Overhead inputs are sampled once per frame so a frame is self-consistent.
  // Snapshot bits 1 to 14 are never sent, as the sync pattern is driven directly.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      oh_q <= '0;
    end else if (bit_tick && at_end) begin
      oh_q <= oh_d;
    end
  end

  // Payload serialiser, most significant bit first.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_q <= 8'h00;
      shift_cnt_q <= 4'h0;
    end else if (bit_tick && pay_slot) begin
      if (shift_cnt_q == 4'h0) begin
        // An empty FIFO loads zeros so stale storage never reaches the line.
        shift_q <= fifo_valid ? {fifo_data[6:0], 1'b0} : 8'h00;
        shift_cnt_q <= 4'h7;
      end else begin
        shift_q <= {shift_q[6:0], 1'b0};
        shift_cnt_q <= shift_cnt_q - 4'h1;
      end
    end
  end

  // Line output and status.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      line_bit_q <= 1'b0;
      line_en_q <= 1'b0;
      frame_start_q <= 1'b0;
      underrun_q <= 1'b0;
    end else begin
      // Line enable lags the tick by one cycle, matching the registered bit.
      line_en_q <= bit_tick;
      frame_start_q <= bit_tick && (pos_q == 13'h0001);
      // Underrun pulses once per starved byte, so a long gap shows as a train of pulses.
      underrun_q <= bit_tick && pay_slot && (shift_cnt_q == 4'h0) && !fifo_valid;
      if (bit_tick) begin
        if (pos_q <= SYNC_LAST) begin
          line_bit_q <= SYNC_PATTERN[4'(SYNC_LAST - pos_q)];
        end else if (pay_slot) begin
          // An empty FIFO sends zero rather than stalling the line.
          line_bit_q <= (shift_cnt_q == 4'h0) ? (fifo_valid & fifo_data[7]) : shift_q[7];
        end else begin
          line_bit_q <= oh_q[idx];
        end
      end
    end
  end

  assign link.line_bit = line_bit_q;
  assign link.line_en = line_en_q;
  assign frame_start = frame_start_q;
  assign underrun = underrun_q;
endmodule // line_framer

/* File: line_deframer.sv */
// Receive end: finds the sync pattern and pulls payload and overhead bits by position.
`timescale 1ns/1ps
module line_deframer
  import frame_map_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  frame_link_if.rx link,
  output logic [7:0] pay_data,
  output logic pay_valid,
  output logic [OH_COUNT:15] frame_overhead_bits,
  output logic frame_valid,
  output logic stuffed,
  output logic locked
);
  logic [13:0] sync_sr_q;
  logic [12:0] pos_q;
  logic [OH_COUNT:15] acc_q;
  logic [7:0] byte_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] pay_data_q;
  logic pay_valid_q;
  logic [OH_COUNT:15] oh_out_q;
  logic frame_valid_q;
  logic stuffed_q;
  logic locked_q;
  logic [13:0] sync_next;
  logic sync_hit;
  logic short_len;
  logic long_len;
  logic [5:0] idx;

  assign sync_next = {sync_sr_q[12:0], link.line_bit};
  assign sync_hit = link.line_en && (sync_next == SYNC_PATTERN);
  // Length of the frame just ended is read from where the next sync lands.
  assign short_len = (pos_q == GRP4_PAY_LAST + SYNC_LAST);
  assign long_len = (pos_q == STUFFED_LAST + SYNC_LAST);
  assign idx = oh_index(pos_q);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_sr_q <= 14'h0000;
      pos_q <= 13'h0000;
      locked_q <= 1'b0;
    end else if (link.line_en) begin
      sync_sr_q <= sync_next;
      if (sync_hit && (!locked_q || short_len || long_len)) begin
        pos_q <= SYNC_LAST + 13'h0001;
        locked_q <= 1'b1;
      end else if (pos_q >= STUFFED_LAST + SYNC_LAST) begin
        // No sync where one must be: alignment is lost.
        locked_q <= 1'b0;
        pos_q <= 13'h0000;
      end else if (locked_q) begin
        pos_q <= pos_q + 13'h0001;
      end
    end
  end

  // Overhead capture; pad symbols are kept only if the frame proves long.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_q <= '0;
      oh_out_q <= '0;
      stuffed_q <= 1'b0;
      frame_valid_q <= 1'b0;
    end else begin
      frame_valid_q <= 1'b0;
      if (link.line_en && locked_q) begin
        if (idx >= 6'd15) begin
          acc_q[idx] <= link.line_bit;
        end
        if (sync_hit && (short_len || long_len)) begin
          oh_out_q <= acc_q;
          // Spare positions are not passed on.
          oh_out_q[26] <= SPARE_FILL;
          oh_out_q[36:34] <= {3{SPARE_FILL}};
          oh_out_q[43] <= SPARE_FILL;
          oh_out_q[46:45] <= {2{SPARE_FILL}};
          if (short_len) begin
            oh_out_q[OH_PAD_SYMBOL2_MAGNITUDE:OH_PAD_SYMBOL1_SIGN] <= 4'h0;
          end
          stuffed_q <= long_len;
          frame_valid_q <= 1'b1;
        end
      end
    end
  end

  // Payload bits regrouped into bytes, first bit most significant.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      byte_q <= 8'h00;
      bit_cnt_q <= 3'h0;
      pay_data_q <= 8'h00;
      pay_valid_q <= 1'b0;
    end else begin
      pay_valid_q <= 1'b0;
      if (link.line_en && locked_q && is_payload(pos_q)) begin
        byte_q <= {byte_q[6:0], link.line_bit};
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (bit_cnt_q == 3'h7) begin
          pay_data_q <= {byte_q[6:0], link.line_bit};
          pay_valid_q <= 1'b1;
        end
      end else if (sync_hit && (!locked_q || short_len || long_len)) begin
        bit_cnt_q <= 3'h0;
      end
    end
  end

  assign pay_data = pay_data_q;
  assign pay_valid = pay_valid_q;
  assign frame_overhead_bits = oh_out_q;
  assign frame_valid = frame_valid_q;
  assign stuffed = stuffed_q;
  assign locked = locked_q;
endmodule // line_deframer

/* File: frame_link_sva.sv */
// Assertions on the serial line between the framer and the deframer.
`timescale 1ns/1ps
module frame_link_sva
  import frame_map_pkg::*;
#(
  parameter int DIV = BIT_DIV
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic line_bit,
  input wire logic line_en
);
  logic [13:0] shift_q;
  logic [12:0] cnt_q;
  logic seen_q;
  logic [12:0] pos;
  logic sync_hit;
  logic spare;
  logic [7:0] gap_q;
  // The count restarts on any pattern match, so payload that mimics the pattern would mislead it.
  assign pos = cnt_q + 13'h0001;
  assign sync_hit = line_en && ({shift_q[12:0], line_bit} == SYNC_PATTERN);
  assign spare = pos inside {13'h04a6, 13'h093a, 13'h093b, 13'h093c, 13'h0dcf, 13'h0dd1, 13'h0dd2};
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_q <= 14'h0000;
      cnt_q <= 13'h0000;
    end else if (line_en) begin
      shift_q <= {shift_q[12:0], line_bit};
      cnt_q <= sync_hit ? SYNC_LAST : pos;
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seen_q <= 1'b0;
    end else if (sync_hit) begin
      seen_q <= 1'b1;
    end
  end
  // Cycles since the last line enable, saturating, so the bit period is checked exactly.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_q <= 8'h00;
    end else if (line_en) begin
      gap_q <= 8'h00;
    end else if (gap_q != 8'hff) begin
      gap_q <= gap_q + 8'h01;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_en_pulse;
    line_en && seen_q |-> gap_q == 8'(DIV - 1);
  endproperty
  a_en_pulse: assert property (p_en_pulse) else $error("line enable is not a lone pulse");
  property p_en_period;
    line_en |-> ##DIV line_en;
  endproperty
  a_en_period: assert property (p_en_period) else $error("line bit period wrong");
  property p_bit_hold;
    $changed(line_bit) |-> line_en;
  endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("line bit moved between enables");
  property p_frame_len;
    sync_hit && seen_q |-> pos == GRP4_PAY_LAST + SYNC_LAST || pos == STUFFED_LAST + SYNC_LAST;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length not short or long");
  property p_no_overrun;
    seen_q |-> cnt_q <= 13'h1270;
  endproperty
  a_no_overrun: assert property (p_no_overrun) else $error("frame ran past its longest length");
  property p_spare_fill;
    line_en && seen_q && spare |-> line_bit == SPARE_FILL;
  endproperty
  a_spare_fill: assert property (p_spare_fill) else $error("spare bit not at fill value");
  property p_after_long;
    line_en && seen_q && pos == STUFFED_LAST + SYNC_LAST |-> sync_hit;
  endproperty
  a_after_long: assert property (p_after_long) else $error("no sync after a long frame");
  property p_first_tick;
    $rose(arst_n) |-> ##[1:200] line_en;
  endproperty
  a_first_tick: assert property (p_first_tick) else $error("line silent after reset");
endmodule // frame_link_sva

/* File: tb_top.sv */
// Testbench joining framer and deframer across the line.
`timescale 1ns/1ps
module tb_top
  import frame_map_pkg::*;
;
  typedef struct packed {logic s; logic [50:15] oh;} row_s;
  logic clk, arst_n, pay_valid, pay_ready, frame_start, underrun, stuff_req;
  logic far_loss, far_block_err, ops_channel_addr_bit_a, ops_channel_addr_bit_b;
  logic ops_channel_opcode_bit, ops_channel_parity_byte_bit, power_state_bit_1, power_state_bit_2;
  logic violation, regen_present, ready_to_receive, pad_symbol1_sign, pad_symbol1_magnitude;
  logic pad_symbol2_sign, pad_symbol2_magnitude, rx_valid, frame_valid, stuffed, locked, urun_seen;
  logic [7:0] pay_data, rx_data, ops_message;
  logic [5:0] check_bits;
  logic [OH_COUNT:15] frame_overhead_bits;
  logic [2:0] ev;
  int bad_count, checked;
  row_s rows [2];
  // A short bit period keeps four frames within a brief run; the frame layout is unchanged.
  localparam int unsigned SIM_DIV = 4;
  frame_link_if frame_link_if_i ();
  line_framer #(.TICK_DIV(SIM_DIV)) line_framer_i (.link(frame_link_if_i), .*);
  line_deframer line_deframer_i (.clk(clk), .arst_n(arst_n), .link(frame_link_if_i), .pay_data(rx_data),
    .pay_valid(rx_valid), .frame_overhead_bits(frame_overhead_bits), .frame_valid(frame_valid),
    .stuffed(stuffed), .locked(locked));
  frame_link_sva #(.DIV(SIM_DIV)) frame_link_sva_i (.clk(clk), .arst_n(arst_n), .line_bit(frame_link_if_i.line_bit),
    .line_en(frame_link_if_i.line_en));
  assign ev = {rx_valid, frame_valid, frame_start};
  always #5 clk = ~clk;
  always @(posedge clk) if (underrun === 1'b1) urun_seen = 1'b1;
  task automatic chk(input logic [35:0] seen, input logic [35:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic wait_ev(input int b, input int lim);
    int n;
    n = 0;
    @(negedge clk);
    while (ev[b] !== 1'b1 && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk(36'(ev[b]), 36'h1, "event wait");
  endtask
  task automatic apply(input row_s r);
    {ops_channel_parity_byte_bit, ops_channel_opcode_bit, ops_channel_addr_bit_b,
      ops_channel_addr_bit_a, far_block_err, far_loss} = r.oh[20:15];
    {violation, power_state_bit_2, power_state_bit_1} = r.oh[25:23];
    check_bits = {r.oh[42:41], r.oh[32:31], r.oh[22:21]};
    ops_message = {r.oh[40:37], r.oh[30:27]};
    regen_present = r.oh[33];
    ready_to_receive = r.oh[44];
    {pad_symbol2_magnitude, pad_symbol2_sign, pad_symbol1_magnitude, pad_symbol1_sign} = r.oh[50:47];
    stuff_req = r.s;
  endtask
  function automatic logic [50:15] expect_oh(input row_s r);
    logic [50:15] e;
    e = r.oh;
    e[26] = 1'b0;
    e[36:34] = 3'h0;
    e[43] = 1'b0;
    e[46:45] = 2'h0;
    if (!r.s) e[50:47] = 4'h0;
    return e;
  endfunction
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Three full frames of about 18800 cycles each at the short bit period, plus margin.
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
  initial begin
    clk = 1'b0;
    arst_n = 1'b0;
    pay_data = 8'h00;
    pay_valid = 1'b0;
    urun_seen = 1'b0;
    rows[0] = '{1'b0, 36'h9a5c3e17b};
    rows[1] = '{1'b1, 36'h65a3c1e84};
    apply(rows[0]);
    repeat (5) @(negedge clk);
    arst_n = 1'b1;
    wait_ev(0, 20000);
    wait_ev(0, 20000);
    // Each frame carries the row applied during the frame before it.
    for (int r = 0; r < 2; r++) begin
      if (r == 0) apply(rows[1]);
      wait_ev(0, 20000);
      wait_ev(1, 2000);
      chk(frame_overhead_bits, expect_oh(rows[r]), "overhead");
      chk(36'(stuffed), 36'(rows[r].s), "stuffed");
    end
    chk(36'(locked), 36'h1, "lock");
    $display("test rows done");
    for (int i = 0; i < 9; i++) begin
      @(negedge clk);
      if (i == 8) chk(36'(pay_ready), 36'h0, "fifo full");
      pay_data = 8'(8'h11 * (i + 1));
      pay_valid = 1'b1;
    end
    @(negedge clk);
    pay_valid = 1'b0;
    urun_seen = 1'b0;
    for (int i = 0; i < 9; i++) begin
      wait_ev(2, 3000);
      chk(36'(rx_data), (i < 8) ? 36'(8'h11 * (i + 1)) : 36'h0, "payload byte");
    end
    chk(36'(urun_seen), 36'h1, "underrun");
    $display("test fifo done");
    arst_n = 1'b0;
    @(negedge clk);
    chk(36'({locked, stuffed, rx_valid, underrun, pay_ready, frame_start, frame_link_if_i.line_en}),
      36'h04, "reset values");
    repeat (4) @(negedge clk);
    arst_n = 1'b1;
    wait_ev(0, 300);
    $display("test reset done");
    give_verdict();
  end
endmodule // tb_top
